// ===== hdl/tsc_edge_sampler.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Event input sampler: finds the first changing 8 ns tap in a clock cycle.
// ==========================================================================
module tsc_edge_sampler #(
  parameter int unsigned TAPS = tsc_pkg::NUM_SLOTS_PER_CLK
) (
  input  wire logic            core_clk,
  input  wire logic            reset,
  input  wire logic [TAPS-1:0] event_taps,
  output logic                 edge_seen,
  output logic                 edge_rising,
  output logic [2:0]           edge_phase
);

  logic [TAPS-1:0] taps_meta_r;
  logic [TAPS-1:0] taps_sync_r;
  logic            last_r;
  logic            primed_r;
  logic [1:0]      warm_r;
  logic [TAPS:0]   chain;
  logic [TAPS-1:0] diff;
  logic [2:0]      first_idx;
  logic            found;
  logic            edge_seen_r;
  logic            edge_rising_r;
  logic [2:0]      edge_phase_r;

  // Tap 0 is the earliest slot; the previous cycle's last tap leads the chain.
  assign chain = {taps_sync_r, last_r};
  assign found = primed_r && (diff != '0);

  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_diff
      assign diff[g] = chain[g+1] ^ chain[g];
    end
  endgenerate

  // A glitch with several changes in one cycle keeps only the earliest.
  always_comb begin
    first_idx = 3'h0;
    for (int i = TAPS - 1; i >= 0; i--) begin
      if (diff[i]) begin
        first_idx = 3'(i);
      end
    end
  end

  // Two-stage synchroniser; the first cycles after reset are not compared.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      taps_meta_r <= '0;
      taps_sync_r <= '0;
      last_r      <= 1'b0;
      primed_r    <= 1'b0;
      warm_r      <= 2'h0;
    end else begin
      taps_meta_r <= event_taps;
      taps_sync_r <= taps_meta_r;
      last_r      <= taps_sync_r[TAPS-1];
      // Compare only once both stages and last_r hold real pin values, so a
      // pin that is already high at reset gives no false edge.
      warm_r      <= (warm_r == 2'h2) ? warm_r : warm_r + 2'h1;
      primed_r    <= primed_r || warm_r == 2'h2;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      edge_seen_r   <= 1'b0;
      edge_rising_r <= 1'b0;
      edge_phase_r  <= 3'h0;
    end else begin
      edge_seen_r   <= found;
      edge_rising_r <= chain[first_idx+3'h1];
      edge_phase_r  <= tsc_pkg::PHASE_CODE[first_idx];
    end
  end

  assign edge_seen   = edge_seen_r;
  assign edge_rising = edge_rising_r;
  assign edge_phase  = edge_phase_r;

  a_phase_code: assert property (
    @(posedge core_clk) disable iff (reset)
    found |=> edge_seen && edge_phase == tsc_pkg::PHASE_CODE[$past(first_idx)])
    else $error("phase code does not match the first changing slot");

  a_slot_early: assert property (
    @(posedge core_clk) disable iff (reset)
    (found && diff[1:0] == 2'b10) |=> edge_phase == 3'h1)
    else $error("second slot edge not reported as 001");

  a_slot_late: assert property (
    @(posedge core_clk) disable iff (reset)
    (found && diff[3:0] == 4'b0000) |=> edge_phase == 3'h4)
    else $error("fifth slot edge not reported as 100");

  a_slot_third: assert property (
    @(posedge core_clk) disable iff (reset)
    (found && diff[2:0] == 3'b100) |=> edge_phase == 3'h2)
    else $error("third slot edge not reported as 010");

endmodule : tsc_edge_sampler
`default_nettype wire

// ===== hdl/tsc_pkg.sv
// ==========================================================================
// Shared constants of the event timestamp sample registers.
// ==========================================================================
package tsc_pkg;

  // Timing clock period and the width of one sub-cycle slot.
  localparam int unsigned CLK_PERIOD_NS     = 40;
  localparam int unsigned SLOT_NS           = 8;
  localparam int unsigned NUM_SLOTS_PER_CLK = CLK_PERIOD_NS / SLOT_NS;

  // Register byte addresses; every offset is word aligned.
  localparam int unsigned ADDR_W                   = 12;
  localparam logic [11:0] ADDR_CAP5_PHASE          = 12'h58c;
  localparam logic [11:0] ADDR_CAP6_NS             = 12'h590;
  localparam logic [11:0] ADDR_CAP6_SEC            = 12'h594;
  localparam logic [11:0] ADDR_CAP6_PHASE          = 12'h598;
  localparam logic [11:0] ADDR_CAP7_NS             = 12'h59c;
  localparam logic [11:0] ADDR_CAP7_SEC            = 12'h5a0;

  // Field positions inside the register words.
  localparam int unsigned NS_EDGE_BIT  = 30;
  localparam int unsigned NS_W         = 30;
  localparam int unsigned SEC_W        = 32;
  localparam int unsigned PHASE_W      = 3;
  localparam logic [31:0] WORD_RESET   = 32'h0000_0000;

  // Stored entry layout: seconds, edge, nanoseconds, phase.
  localparam int unsigned ENTRY_PHASE_LSB = 0;
  localparam int unsigned ENTRY_NS_LSB    = PHASE_W;
  localparam int unsigned ENTRY_EDGE_BIT  = PHASE_W + NS_W;
  localparam int unsigned ENTRY_SEC_LSB   = ENTRY_EDGE_BIT + 1;
  localparam int unsigned ENTRY_W         = ENTRY_SEC_LSB + SEC_W;

  // Sample slots held here: the fifth, sixth and seventh capture.
  localparam int unsigned NUM_CAPTURE_SLOTS = 3;
  localparam logic [1:0]  FILL_FULL         = 2'h3;

  // slot codes; the third slot uses 010, as 101 up is reserved.
  localparam logic [2:0] PHASE_CODE [0:4] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

  typedef enum logic [1:0] {FLD_NONE, FLD_NS, FLD_SEC, FLD_PHASE} tsc_field_e;
  typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} tsc_bus_state_e;

  // Which field a register address selects.
  function automatic tsc_field_e addr_field(input logic [11:0] a);
    unique case (a)
      ADDR_CAP5_PHASE, ADDR_CAP6_PHASE: addr_field = FLD_PHASE;
      ADDR_CAP6_NS, ADDR_CAP7_NS:       addr_field = FLD_NS;
      ADDR_CAP6_SEC, ADDR_CAP7_SEC:     addr_field = FLD_SEC;
      default:                          addr_field = FLD_NONE;
    endcase
  endfunction : addr_field

  // Which stored slot (0 = fifth sample) a register address selects.
  function automatic logic [1:0] addr_slot(input logic [11:0] a);
    if (a < ADDR_CAP6_NS) begin
      addr_slot = 2'h0;
    end else if (a < ADDR_CAP7_NS) begin
      addr_slot = 2'h1;
    end else begin
      addr_slot = 2'h2;
    end
  endfunction : addr_slot

endpackage : tsc_pkg

// ===== hdl/tsc_sample_regs.sv
// Notes on behaviour
// - Phase field names the 8 ns slot.
// - First slot reads 000, second reads 001.
// - Fourth slot reads 011, fifth reads 100.
// - Third slot reads 010, not reserved 101.
// - Nanoseconds bit 30 holds edge polarity.
// - Nanoseconds bits 29:0 hold captured nanoseconds.
// - Seconds word holds full 32-bit seconds.
// - Unit index selects which unit reads.
// - Words sit at consecutive aligned addresses.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tsc_sample_regs #(
  parameter int unsigned NUM_UNITS = 2,
  parameter int unsigned TAPS      = tsc_pkg::NUM_SLOTS_PER_CLK,
  parameter int unsigned UNIT_W    = 1
) (
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [NUM_UNITS*TAPS-1:0] event_taps,
  input  wire logic [UNIT_W-1:0]         unit_index_ptr,
  input  wire logic [31:0]               tod_seconds,
  input  wire logic [29:0]               tod_nanoseconds,
  input  wire logic                      capture_rearm
);

  // ========================================================================
  // Capture units
  // ========================================================================
  logic [NUM_UNITS-1:0]          ev_seen;
  logic [NUM_UNITS-1:0]          ev_rise;
  logic [2:0]                    ev_phase   [NUM_UNITS];
  logic [1:0]                    fill_r     [NUM_UNITS];
  logic [2:0]                    valid_r    [NUM_UNITS];
  logic [tsc_pkg::ENTRY_W-1:0]   rd_entry   [NUM_UNITS];
  logic [NUM_UNITS-1:0]          cap_we;
  logic [1:0]                    cap_addr   [NUM_UNITS];
  logic                          rd_en;
  logic [1:0]                    rd_slot;

  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      logic [tsc_pkg::ENTRY_W-1:0] cap_data;

      tsc_edge_sampler #(
        .TAPS        (TAPS)
      ) u_sampler (
        .core_clk    (core_clk),
        .reset       (reset),
        .event_taps  (event_taps[u*TAPS +: TAPS]),
        .edge_seen   (ev_seen[u]),
        .edge_rising (ev_rise[u]),
        .edge_phase  (ev_phase[u])
      );

      // A rearm restarts filling at the fifth slot; an edge in that cycle
      // still lands, so no event is lost to a coincident rearm.
      assign cap_we[u]   = ev_seen[u] && (capture_rearm || fill_r[u] != tsc_pkg::FILL_FULL);
      assign cap_addr[u] = capture_rearm ? 2'h0 : fill_r[u];
      assign cap_data    = {tod_seconds, ev_rise[u], tod_nanoseconds, ev_phase[u]};

      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          fill_r[u]  <= 2'h0;
          valid_r[u] <= 3'h0;
        end else if (capture_rearm) begin
          fill_r[u]  <= cap_we[u] ? 2'h1 : 2'h0;
          valid_r[u] <= {2'h0, cap_we[u]};
        end else if (cap_we[u]) begin
          fill_r[u]  <= fill_r[u] + 2'h1;
          valid_r[u] <= valid_r[u] | (3'h1 << fill_r[u]);
        end
      end

      tsc_slot_mem #(
        .DW      (tsc_pkg::ENTRY_W),
        .DEPTH   (4)
      ) u_mem (
        .core_clk(core_clk),
        .reset   (reset),
        .wr_en   (cap_we[u]),
        .wr_addr (cap_addr[u]),
        .wr_data (cap_data),
        .rd_en   (rd_en),
        .rd_addr (rd_slot),
        .rd_data (rd_entry[u])
      );

      a_fill_order: assert property (
        @(posedge core_clk) disable iff (reset)
        (cap_we[u] && !capture_rearm) |=>
          fill_r[u] == $past(fill_r[u]) + 2'h1 && valid_r[u][$past(fill_r[u])])
        else $error("capture did not take the next free slot");

      a_full_hold: assert property (
        @(posedge core_clk) disable iff (reset)
        (fill_r[u] == tsc_pkg::FILL_FULL && !capture_rearm) |=> $stable(valid_r[u]))
        else $error("full unit changed without a rearm");

      a_rearm_clear: assert property (
        @(posedge core_clk) disable iff (reset)
        capture_rearm |=> valid_r[u] == {2'h0, $past(cap_we[u])})
        else $error("rearm did not empty the unit");

      a_full_drop: assert property (
        @(posedge core_clk) disable iff (reset)
        (fill_r[u] == tsc_pkg::FILL_FULL && !capture_rearm) |-> !cap_we[u])
        else $error("edge stored into a full unit");
    end
  endgenerate

  // ========================================================================
  // APB slave
  // ========================================================================
  tsc_pkg::tsc_bus_state_e state_r;
  tsc_pkg::tsc_field_e     fld_r;
  tsc_pkg::tsc_field_e     setup_fld;
  logic [UNIT_W-1:0]       unit_r;
  logic                    write_r;
  logic                    hit_valid_r;
  logic [31:0]             prdata_r;
  logic                    pslverr_r;
  logic                    setup;
  logic                    done;
  logic [tsc_pkg::ENTRY_W-1:0] sel_entry;
  logic [31:0]             word_nxt;
  logic [31:0]             ns_word;
  logic [31:0]             sec_word;
  logic [31:0]             phase_word;

  assign setup_fld = tsc_pkg::addr_field(paddr);
  assign rd_slot   = tsc_pkg::addr_slot(paddr);
  assign setup     = psel && !penable && state_r == tsc_pkg::BUS_IDLE;
  assign rd_en     = setup;
  assign done      = psel && penable && state_r == tsc_pkg::BUS_ANSWER;

  assign sel_entry = rd_entry[unit_r];

  // edge bit, nanoseconds, bit 31 zero.
  assign ns_word = {1'b0, sel_entry[tsc_pkg::ENTRY_EDGE_BIT],
                    sel_entry[tsc_pkg::ENTRY_NS_LSB +: tsc_pkg::NS_W]};
  assign sec_word = sel_entry[tsc_pkg::ENTRY_SEC_LSB +: tsc_pkg::SEC_W];
  assign phase_word = {29'h0, sel_entry[tsc_pkg::ENTRY_PHASE_LSB +: tsc_pkg::PHASE_W]};

  // A slot never written reads its reset value rather than stale memory.
  assign word_nxt = !hit_valid_r               ? tsc_pkg::WORD_RESET :
                    fld_r == tsc_pkg::FLD_NS    ? ns_word :
                    fld_r == tsc_pkg::FLD_SEC   ? sec_word :
                    fld_r == tsc_pkg::FLD_PHASE ? phase_word : tsc_pkg::WORD_RESET;

  // Setup latches the request; valid bits are taken at the same edge as the
  // memory read so data and valid always agree.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fld_r       <= tsc_pkg::FLD_NONE;
      unit_r      <= '0;
      write_r     <= 1'b0;
      hit_valid_r <= 1'b0;
    end else if (setup) begin
      fld_r       <= setup_fld;
      unit_r      <= unit_index_ptr;
      write_r     <= pwrite;
      hit_valid_r <= valid_r[unit_index_ptr][rd_slot];
    end
  end

  // Three-phase answer: fetch, register the word, then raise pready.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_r   <= tsc_pkg::BUS_IDLE;
      prdata_r  <= tsc_pkg::WORD_RESET;
      pslverr_r <= 1'b0;
    end else begin
      unique case (state_r)
        tsc_pkg::BUS_IDLE: begin
          if (setup) begin
            state_r <= tsc_pkg::BUS_FETCH;
          end
        end
        tsc_pkg::BUS_FETCH: begin
          state_r   <= tsc_pkg::BUS_ANSWER;
          pslverr_r <= fld_r == tsc_pkg::FLD_NONE;
          if (!write_r) begin
            prdata_r <= word_nxt;
          end
        end
        tsc_pkg::BUS_ANSWER: begin
          if (done || !psel) begin
            state_r <= tsc_pkg::BUS_IDLE;
          end
        end
        default: begin
          state_r <= tsc_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  assign pready  = state_r == tsc_pkg::BUS_ANSWER;
  assign pslverr = pready && pslverr_r;
  assign prdata  = prdata_r;

  sequence s_setup;
    psel && !penable && state_r == tsc_pkg::BUS_IDLE;
  endsequence

  sequence s_answer;
    ##2 pready;
  endsequence

  a_read_latency: assert property (
    @(posedge core_clk) disable iff (reset)
    s_setup |-> s_answer)
    else $error("register answer not two cycles after setup");

  a_unmapped_error: assert property (
    @(posedge core_clk) disable iff (reset)
    (s_setup and (tsc_pkg::addr_field(paddr) == tsc_pkg::FLD_NONE)) |-> ##2 pslverr)
    else $error("unmapped address answered without error");

  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (reset)
    (pready && !write_r && fld_r == tsc_pkg::FLD_PHASE) |-> prdata[31:3] == 29'h0)
    else $error("phase word reserved bits not zero");

  a_write_ignored: assert property (
    @(posedge core_clk) disable iff (reset)
    (state_r == tsc_pkg::BUS_FETCH && write_r) |=> $stable(prdata) && !pslverr_r
      || fld_r == tsc_pkg::FLD_NONE)
    else $error("write to a read-only word changed read data");

  a_unit_select: assert property (
    @(posedge core_clk) disable iff (reset)
    s_setup |=> unit_r == $past(unit_index_ptr))
    else $error("read did not follow the unit index pointer");

  a_ns_word: assert property (
    @(posedge core_clk) disable iff (reset)
    (state_r == tsc_pkg::BUS_FETCH && !write_r && hit_valid_r && fld_r == tsc_pkg::FLD_NS)
      |=> prdata[31] == 1'b0 &&
          prdata[30] == $past(sel_entry[tsc_pkg::ENTRY_EDGE_BIT]))
    else $error("edge polarity not in bit 30");

  a_seconds_word: assert property (
    @(posedge core_clk) disable iff (reset)
    (state_r == tsc_pkg::BUS_FETCH && !write_r && fld_r == tsc_pkg::FLD_SEC)
      |=> prdata == ($past(hit_valid_r) ? $past(sec_word) : 32'h0))
    else $error("seconds word wrong");

  // A read in its fetch cycle, shared by the field checks below.
  sequence s_fetch_read;
    state_r == tsc_pkg::BUS_FETCH && !write_r;
  endsequence

  a_ns_field: assert property (
    @(posedge core_clk) disable iff (reset)
    s_fetch_read ##0 (hit_valid_r && fld_r == tsc_pkg::FLD_NS)
      |=> prdata[29:0] == $past(sel_entry[tsc_pkg::ENTRY_NS_LSB +: tsc_pkg::NS_W]))
    else $error("nanoseconds field wrong");

  a_phase_word: assert property (
    @(posedge core_clk) disable iff (reset)
    s_fetch_read ##0 (hit_valid_r && fld_r == tsc_pkg::FLD_PHASE)
      |=> prdata[2:0] == $past(sel_entry[tsc_pkg::ENTRY_PHASE_LSB +: tsc_pkg::PHASE_W]))
    else $error("phase field wrong");

  // An empty slot must read as zero, whatever the memory still holds.
  a_empty_zero: assert property (
    @(posedge core_clk) disable iff (reset)
    s_fetch_read ##0 (!hit_valid_r) |=> prdata == tsc_pkg::WORD_RESET)
    else $error("empty slot did not read zero");

  a_ns_reserved: assert property (
    @(posedge core_clk) disable iff (reset)
    (pready && !write_r && fld_r == tsc_pkg::FLD_NS) |-> !prdata[31])
    else $error("nanoseconds word bit 31 not zero");

  // The answer stands for one access only; a stuck one would end the next transfer.
  a_answer_once: assert property (
    @(posedge core_clk) disable iff (reset)
    (pready && psel && penable) |=> !pready)
    else $error("pready held past the completing edge");

  a_error_unmapped: assert property (
    @(posedge core_clk) disable iff (reset)
    pslverr |-> fld_r == tsc_pkg::FLD_NONE)
    else $error("error answer on a mapped address");

endmodule : tsc_sample_regs
`default_nettype wire

// ===== hdl/tsc_slot_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Small sample store with one write port and a registered read port.
// ==========================================================================
module tsc_slot_mem #(
  parameter int unsigned DW    = tsc_pkg::ENTRY_W,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [DW-1:0]            wr_data,
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [DW-1:0]            rd_data
);

  logic [DW-1:0] mem_r [DEPTH];
  logic [DW-1:0] rd_data_r;

  // The array has no reset; callers keep a valid bit per word instead.
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read is old-data on a same-address write.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = rd_data_r;

endmodule : tsc_slot_mem
`default_nettype wire

// ===== test/tsc_sample_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tsc_sample_regs_tb_top;

  // ==========================================================================
  // Design inputs, observed outputs and bench bookkeeping.
  // ==========================================================================
  localparam int unsigned LIMIT = 20000;

  logic        core_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  event_taps;
  logic [0:0]  unit_index_ptr;
  logic [31:0] tod_seconds;
  logic [29:0] tod_nanoseconds;
  logic        capture_rearm;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches;
  int          checked;
  int          cycles;
  int          cnt [0:1];
  logic [31:0] e_ns [0:1][0:2];
  logic [31:0] e_sec [0:1][0:2];
  logic [2:0]  e_ph [0:1][0:2];

  tsc_sample_regs dut (
    .core_clk        (core_clk),
    .reset           (reset),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .pstrb           (pstrb),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .event_taps      (event_taps),
    .unit_index_ptr  (unit_index_ptr),
    .tod_seconds     (tod_seconds),
    .tod_nanoseconds (tod_nanoseconds),
    .capture_rearm   (capture_rearm)
  );

  // 25 MHz clock.
  always #20 core_clk = ~core_clk;

  // A hung handshake would stall the run, so a cycle ceiling ends it.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  // ==========================================================================
  // Checking and bus tasks.
  // ==========================================================================
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rdat, rerr);
    chk($sformatf("read %h", a), rdat, exp);
    chk($sformatf("error flag %h", a), {31'h0, rerr}, 32'h0000_0000);
  endtask : rdchk

  // Unmapped or unaligned places answer with an error and zero data.
  task automatic errchk(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000, rdat, rerr);
    chk($sformatf("read %h", a), rdat, 32'h0000_0000);
    chk($sformatf("error flag %h", a), {31'h0, rerr}, 32'h0000_0001);
  endtask : errchk

  task automatic clear_exp();
    for (int u = 0; u < 2; u++) begin
      cnt[u] = 0;
      for (int s = 0; s < 3; s++) begin
        e_ns[u][s]  = 32'h0000_0000;
        e_sec[u][s] = 32'h0000_0000;
        e_ph[u][s]  = 3'h0;
      end
    end
  endtask : clear_exp

  // Pin of unit u changes inside slot k; the time of day stands still across the store.
  task automatic edge_ev(input int u, input logic rise, input int k, input int id);
    logic [31:0] s;
    logic [29:0] n;
    logic [4:0]  p;
    s = 32'h8123_0000 + 32'(id);
    n = 30'h3abc_0000 ^ 30'(id * 7);
    p = rise ? (5'h1f << k) : ~(5'h1f << k);
    @(posedge core_clk);
    tod_seconds     <= s;
    tod_nanoseconds <= n;
    @(posedge core_clk);
    event_taps[u*5 +: 5] <= p;
    @(posedge core_clk);
    event_taps[u*5 +: 5] <= {5{rise}};
    repeat (6) @(posedge core_clk);
    if (cnt[u] < 3) begin
      e_ns[u][cnt[u]]  = {1'b0, rise, n};
      e_sec[u][cnt[u]] = s;
      e_ph[u][cnt[u]]  = 3'(k);
      cnt[u]++;
    end
  endtask : edge_ev

  // Reads every word of one unit through the unit pointer.
  task automatic verify(input int u);
    @(posedge core_clk);
    unit_index_ptr <= u[0:0];
    rdchk(tsc_pkg::ADDR_CAP5_PHASE, {29'h0, e_ph[u][0]});
    rdchk(tsc_pkg::ADDR_CAP6_NS, e_ns[u][1]);
    rdchk(tsc_pkg::ADDR_CAP6_SEC, e_sec[u][1]);
    rdchk(tsc_pkg::ADDR_CAP6_PHASE, {29'h0, e_ph[u][1]});
    rdchk(tsc_pkg::ADDR_CAP7_NS, e_ns[u][2]);
    rdchk(tsc_pkg::ADDR_CAP7_SEC, e_sec[u][2]);
  endtask : verify

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    core_clk        = 1'b0;
    reset           = 1'b1;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0000_0000;
    pstrb           = 4'hf;
    event_taps      = 10'h000;
    unit_index_ptr  = 1'b0;
    tod_seconds     = 32'h0000_0000;
    tod_nanoseconds = 30'h0000_0000;
    capture_rearm   = 1'b0;
    mismatches      = 0;
    checked         = 0;
    cycles          = 0;
    clear_exp();
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("prdata after reset", prdata, 32'h0000_0000);
    chk("pready after reset", {31'h0, pready}, 32'h0000_0000);
    chk("pslverr after reset", {31'h0, pslverr}, 32'h0000_0000);
    verify(0);
    verify(1);
    errchk(12'h584);
    errchk(12'h5a4);
    errchk(12'h591);
    // Unit 0 takes four edges; the fourth finds the slots full and is dropped.
    edge_ev(0, 1'b1, 4, 1);
    edge_ev(0, 1'b0, 1, 2);
    edge_ev(0, 1'b1, 2, 3);
    edge_ev(0, 1'b0, 0, 4);
    edge_ev(1, 1'b1, 3, 5);
    edge_ev(1, 1'b0, 0, 6);
    edge_ev(1, 1'b1, 1, 7);
    verify(0);
    verify(1);
    apb(1'b1, tsc_pkg::ADDR_CAP6_SEC, 32'hffff_ffff, rdat, rerr);
    chk("write error flag", {31'h0, rerr}, 32'h0000_0000);
    apb(1'b1, tsc_pkg::ADDR_CAP5_PHASE, 32'hffff_ffff, rdat, rerr);
    chk("write error flag", {31'h0, rerr}, 32'h0000_0000);
    rdchk(tsc_pkg::ADDR_CAP6_SEC, e_sec[1][1]);
    rdchk(tsc_pkg::ADDR_CAP5_PHASE, {29'h0, e_ph[1][0]});
    // Rearm empties every slot; the next edge goes to the fifth sample again.
    @(posedge core_clk);
    capture_rearm <= 1'b1;
    @(posedge core_clk);
    capture_rearm <= 1'b0;
    clear_exp();
    verify(0);
    verify(1);
    edge_ev(0, 1'b1, 2, 8);
    verify(0);
    final_report();
  end

endmodule : tsc_sample_regs_tb_top
`default_nettype wire
